// [rtl/dma_completion_irq_regs.sv]
/*
 * transmit completion interrupt registers of the packet dma: vector
 * copy, raw and masked completion status, enable mask with set and
 * clear ports, receive dma enable. reached over axi4-lite.
 * assumes single 10 MHz clock aclk and synchronous inputs.
 */
`include "dma_irq_defs.svh"

// What this block does
// - vector register samples external vector each clock
// - per-channel raw completion flags, channels 3..0
// - masked status equals raw AND enable
// - four active-high completion interrupt enable bits
// - enable-clear write of 1 clears enable bit
// - receive dma enable bit 0, read/write
// - fields reset zero; reserved bits read zero
// - enable-set write of 1 sets enable bit
module dma_completion_irq_regs
  import dma_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire reg_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire reg_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire reg_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output reg_data_t s_axi_rdata,
  output axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dma state logic side
  input wire chan_mask_t tx_done_pulse,
  input wire reg_data_t intr_vector_in,
  output logic rx_dma_on,
  output logic tx_completion_irq
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic is_mapped(input reg_addr_t a);
    case (a)
      `OFS_VECTOR, `OFS_MASKED, `OFS_RAW,
      `OFS_EN_SET, `OFS_EN_CLR, `OFS_RX_CTRL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic reg_data_t pad_chan(input chan_mask_t m);
    pad_chan = {{(`DATA_W-`CHAN_N){1'b0}}, m};
  endfunction

  reg_access_if ra ();

  reg_data_t vec_r;
  chan_mask_t en_r, en_nxt;
  chan_mask_t raw_r;
  logic rx_on_r;
  logic lane0_wr;
  logic raw_rd;

  assign lane0_wr = ra.wr_stb && ra.wr_strb[0];
  assign raw_rd = ra.rd_stb && (ra.rd_addr == `OFS_RAW);
  assign rx_dma_on = rx_on_r;

  // ************************************************************
  // bus slave
  // ************************************************************
  axi_lite_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .ra(ra.bus)
  );

  // ************************************************************
  // completion flags and interrupt
  // ************************************************************
  tx_completion_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .done_pulse(tx_done_pulse),
    .clear_all(raw_rd),
    .enable(en_r),
    .raw_r(raw_r),
    .irq_r(tx_completion_irq)
  );

  // ************************************************************
  // vector copy
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_r <= `RST_VECTOR;
    end else begin
      vec_r <= intr_vector_in;
    end
  end

  // ************************************************************
  // enable mask: set and clear ports
  // ************************************************************
  always_comb begin
    en_nxt = en_r;
    if (lane0_wr && ra.wr_addr == `OFS_EN_SET) begin
      en_nxt = en_r | ra.wr_data[`CHAN_N-1:0];
    end else if (lane0_wr && ra.wr_addr == `OFS_EN_CLR) begin
      en_nxt = en_r & ~ra.wr_data[`CHAN_N-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= `RST_CHAN;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ************************************************************
  // receive dma control
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_on_r <= `RST_RX_ON;
    end else if (lane0_wr && ra.wr_addr == `OFS_RX_CTRL) begin
      rx_on_r <= ra.wr_data[`RX_ON_BIT];
    end
  end

  // ************************************************************
  // read mux and errors
  // ************************************************************
  assign ra.wr_err = !is_mapped(ra.wr_addr);
  assign ra.rd_err = !is_mapped(ra.rd_addr);

  always_comb begin
    case (ra.rd_addr)
      `OFS_VECTOR: ra.rd_data = vec_r;
      `OFS_MASKED: ra.rd_data = pad_chan(raw_r & en_r);
      `OFS_RAW: ra.rd_data = pad_chan(raw_r);
      `OFS_EN_SET: ra.rd_data = pad_chan(en_r);
      `OFS_EN_CLR: ra.rd_data = pad_chan(en_r);
      `OFS_RX_CTRL: ra.rd_data = {31'h0, rx_on_r};
      default: ra.rd_data = '0;
    endcase
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_vector_copy:
    assert property (##1 vec_r == $past(intr_vector_in))
    else $error("vector register missed the input");

  a_vector_read:
    assert property (ra.rd_stb && ra.rd_addr == `OFS_VECTOR
                     |=> s_axi_rvalid && s_axi_rdata == $past(vec_r))
    else $error("vector read returned wrong data");

  a_raw_set:
    assert property (tx_done_pulse != 4'h0
                     |=> (raw_r & $past(tx_done_pulse))
                         == $past(tx_done_pulse))
    else $error("completion pulse did not set raw flag");

  a_raw_sticky:
    assert property (!raw_rd && tx_done_pulse == 4'h0 |=> $stable(raw_r))
    else $error("raw flag changed without cause");

  a_masked_and:
    assert property (ra.rd_stb && ra.rd_addr == `OFS_MASKED
                     |=> s_axi_rdata == pad_chan($past(raw_r & en_r)))
    else $error("masked status is not raw and enable");

  a_enable_hold:
    assert property (!lane0_wr |=> $stable(en_r))
    else $error("enable mask changed without a write");

  a_enable_clear:
    assert property (lane0_wr && ra.wr_addr == `OFS_EN_CLR
                     |=> en_r == ($past(en_r)
                                  & ~$past(ra.wr_data[3:0])))
    else $error("enable clear port misbehaved");

  a_enable_set:
    assert property (lane0_wr && ra.wr_addr == `OFS_EN_SET
                     |=> en_r == ($past(en_r)
                                  | $past(ra.wr_data[3:0])))
    else $error("enable set port misbehaved");

  a_rx_ctrl_wr:
    assert property (lane0_wr && ra.wr_addr == `OFS_RX_CTRL
                     |=> rx_dma_on == $past(ra.wr_data[0]))
    else $error("receive enable did not follow write");

  a_reserved_zero:
    assert property (ra.rd_stb && ra.rd_addr != `OFS_VECTOR
                     |=> s_axi_rdata[31:4] == 28'h0000000)
    else $error("reserved bits read nonzero");

  a_irq_level:
    assert property (##1 tx_completion_irq == |$past(raw_r & en_r))
    else $error("interrupt does not follow masked status");

  a_write_resp:
    assert property (ra.wr_stb
                     |=> s_axi_bvalid && s_axi_bresp
                         == ($past(ra.wr_err) ? RESP_SLVERR : RESP_OKAY))
    else $error("write response missing or wrong");

  a_read_resp:
    assert property (ra.rd_stb
                     |=> s_axi_rvalid && s_axi_rresp
                         == ($past(ra.rd_err) ? RESP_SLVERR : RESP_OKAY))
    else $error("read response missing or wrong");

  a_raw_read:
    assert property (ra.rd_stb && ra.rd_addr == `OFS_RAW
                     |=> s_axi_rdata == pad_chan($past(raw_r)))
    else $error("raw status read returned wrong data");

  a_raw_clear:
    assert property (raw_rd |=> raw_r == $past(tx_done_pulse))
    else $error("raw read did not clear or lost a completion");

  a_enable_read:
    assert property (ra.rd_stb && (ra.rd_addr == `OFS_EN_SET
                                   || ra.rd_addr == `OFS_EN_CLR)
                     |=> s_axi_rdata == pad_chan($past(en_r)))
    else $error("enable mask read returned wrong data");

  a_rx_ctrl_hold:
    assert property (!(lane0_wr && ra.wr_addr == `OFS_RX_CTRL)
                     |=> $stable(rx_dma_on))
    else $error("receive enable changed without a write");

  a_rx_ctrl_read:
    assert property (ra.rd_stb && ra.rd_addr == `OFS_RX_CTRL
                     |=> s_axi_rdata[0] == $past(rx_on_r))
    else $error("receive enable read returned wrong data");

  a_ctrl_reserved:
    assert property (ra.rd_stb && ra.rd_addr == `OFS_RX_CTRL
                     |=> s_axi_rdata[31:1] == 31'h0)
    else $error("control reserved bits read nonzero");

  a_reset_clear:
    assert property (disable iff (1'b0)
                     !aresetn |=> en_r == 4'h0 && raw_r == 4'h0
                                  && !rx_dma_on && !tx_completion_irq)
    else $error("state not cleared by reset");

  a_error_read_zero:
    assert property (ra.rd_stb && ra.rd_err |=> s_axi_rdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");

  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed before taken");

  c_irq_raised:
    cover property (tx_done_pulse != 4'h0 && en_r != 4'h0
                    ##2 tx_completion_irq);
  c_set_on_clear:
    cover property (raw_rd && tx_done_pulse != 4'h0);
  c_enable_set_then_clear:
    cover property (lane0_wr && ra.wr_addr == `OFS_EN_SET
                    ##[1:20] lane0_wr && ra.wr_addr == `OFS_EN_CLR);
  c_unmapped_read:
    cover property (ra.rd_stb && ra.rd_err);

endmodule // dma_completion_irq_regs

// [rtl/dma_irq_defs.svh]
/*
 * constants of the transmit completion interrupt register block:
 * register offsets, field widths and positions, reset values.
 * assumes a 10 MHz bus clock and 8-bit byte addresses on a 32-bit bus.
 */
`ifndef DMA_IRQ_DEFS_SVH
`define DMA_IRQ_DEFS_SVH

// ************************************************************
// bus geometry
// ************************************************************
`define ADDR_W 8
`define DATA_W 32
`define CHAN_N 4

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_VECTOR 8'h00
`define OFS_MASKED 8'h04
`define OFS_RAW 8'h08
`define OFS_EN_SET 8'h0c
`define OFS_EN_CLR 8'h10
`define OFS_RX_CTRL 8'h14

// ************************************************************
// fields and reset values
// ************************************************************
`define RX_ON_BIT 0
`define RST_VECTOR 32'h0000_0000
`define RST_CHAN 4'h0
`define RST_RX_ON 1'b0

`endif

// [rtl/dma_irq_pkg.sv]
/*
 * types shared by the completion interrupt register block.
 * assumes dma_irq_defs.svh for the widths.
 */
`include "dma_irq_defs.svh"

package dma_irq_pkg;

  typedef logic [`CHAN_N-1:0] chan_mask_t;
  typedef logic [`ADDR_W-1:0] reg_addr_t;
  typedef logic [`DATA_W-1:0] reg_data_t;

  // axi response codes used by this slave
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage : dma_irq_pkg

// [rtl/reg_access_if.sv]
/*
 * internal register access strobes between the axi-lite slave and
 * the register core. assumes one clock domain; strobes are one cycle.
 */
interface reg_access_if;
  import dma_irq_pkg::*;

  logic wr_stb;
  reg_addr_t wr_addr;
  reg_data_t wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_stb;
  reg_addr_t rd_addr;
  reg_data_t rd_data;
  logic rd_err;

  modport bus (
    output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
    input wr_err, rd_data, rd_err
  );
  modport core (
    input wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface : reg_access_if

// [rtl/axi_lite_slave.sv]
/*
 * axi4-lite slave front end: takes write address and data in either
 * order, issues one write strobe, then a response; one read at a time.
 * assumes the core answers rd_data and the error flags combinationally.
 */
module axi_lite_slave
  import dma_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire reg_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire reg_data_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire reg_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output reg_data_t rdata,
  output axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  reg_access_if.bus ra
);

  reg_addr_t awaddr_r, araddr_r;
  reg_data_t wdata_r;
  logic [3:0] wstrb_r;

  // write commits once both halves are held and no response is pending
  assign ra.wr_stb = !awready && !wready && !bvalid;
  assign ra.wr_addr = awaddr_r;
  assign ra.wr_data = wdata_r;
  assign ra.wr_strb = wstrb_r;
  assign ra.rd_stb = !arready && !rvalid;
  assign ra.rd_addr = araddr_r;

  // ************************************************************
  // write address and data capture
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awaddr_r <= awaddr;
    end else if (ra.wr_stb) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (ra.wr_stb) begin
      wready <= 1'b1;
    end
  end

  // ************************************************************
  // write response
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ra.wr_stb) begin
      bvalid <= 1'b1;
      bresp <= ra.wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // read address, data and response
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      araddr_r <= '0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      araddr_r <= araddr;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ra.rd_stb) begin
      rvalid <= 1'b1;
      rdata <= ra.rd_data;
      rresp <= ra.rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // axi_lite_slave

// [rtl/tx_completion_flags.sv]
/*
 * per-channel sticky transmit completion flags and the level interrupt.
 * assumes done pulses are one cycle per finished packet.
 */
module tx_completion_flags
  import dma_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events and control
  input wire chan_mask_t done_pulse,
  input wire logic clear_all,
  input wire chan_mask_t enable,
  // state
  output chan_mask_t raw_r,
  output logic irq_r
);

  chan_mask_t raw_nxt;

  // a completion in the clearing cycle survives the clear
  always_comb begin
    raw_nxt = (clear_all ? `RST_CHAN : raw_r) | done_pulse;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_r <= `RST_CHAN;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(raw_r & enable);
    end
  end

endmodule // tx_completion_flags

// [sim/dma_completion_irq_regs_test.sv]
/*
 * self-checking bench of the completion interrupt register block:
 * axi4-lite register traffic, completion pulses and vector input.
 * assumes dma_irq_defs.svh and the design files are compiled first.
 */
`include "dma_irq_defs.svh"

module dma_completion_irq_regs_test
  import dma_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk, aresetn;
  reg_addr_t awaddr, araddr;
  reg_data_t wdata, rdata, intr_vector_in, v, d;
  logic [3:0] wstrb, strb_use;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_dma_on, tx_completion_irq;
  axi_resp_t bresp, rresp, r;
  chan_mask_t tx_done_pulse, en_m, raw_m, p;
  int fails, samples_checked, cycles;
  reg_addr_t offs [6] = '{`OFS_VECTOR, `OFS_MASKED, `OFS_RAW,
                          `OFS_EN_SET, `OFS_EN_CLR, `OFS_RX_CTRL};

  dma_completion_irq_regs u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_done_pulse(tx_done_pulse), .intr_vector_in(intr_vector_in),
    .rx_dma_on(rx_dma_on), .tx_completion_irq(tx_completion_irq)
  );

  always #50 aclk = ~aclk;

  // ************************************************************
  // expectations and reporting
  // ************************************************************
  function automatic reg_data_t low4(input chan_mask_t m);
    return {28'h0, m};
  endfunction

  function automatic reg_data_t irq_exp(input chan_mask_t rw,
                                        input chan_mask_t en);
    return {31'h0, |(rw & en)};
  endfunction

  task automatic chk(input reg_data_t got, input reg_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got,
               exp);
      fails++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // ************************************************************
  // bus and event drivers
  // ************************************************************
  task automatic wr(input reg_addr_t a, input reg_data_t dv,
                    output axi_resp_t rs);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dv;
    wstrb <= strb_use;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input reg_addr_t a, output reg_data_t dv,
                    output axi_resp_t rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic pulse(input chan_mask_t m);
    @(posedge aclk);
    tx_done_pulse <= m;
    @(posedge aclk);
    tx_done_pulse <= '0;
    raw_m = raw_m | m;
    repeat (3) @(posedge aclk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    strb_use = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    tx_done_pulse = '0;
    intr_vector_in = '0;
    en_m = '0;
    raw_m = '0;
    void'($urandom(32'h1cfa));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], d, r);
      chk(d, 32'h0);
    end
    chk({31'h0, rx_dma_on}, 32'h0);
    chk({31'h0, tx_completion_irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $urandom();
      @(posedge aclk);
      intr_vector_in <= v;
      rd(`OFS_VECTOR, d, r);
      chk(d, v);
    end
    // unmapped and unaligned places answer with an error
    for (int i = 0; i < 2; i++) begin
      wr(i[0] ? 8'h05 : 8'h18, 32'hffff_ffff, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(i[0] ? 8'h05 : 8'h18, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
    end
    wr(`OFS_MASKED, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(`OFS_MASKED, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      d[0] = i[0];
      wr(`OFS_RX_CTRL, d, r);
      rd(`OFS_RX_CTRL, v, r);
      chk(v, {31'h0, d[0]});
      chk({31'h0, rx_dma_on}, {31'h0, d[0]});
    end
    for (int i = 0; i < 16; i++) begin
      d = $urandom();
      if ($urandom_range(1) == 1) begin
        wr(`OFS_EN_SET, d, r);
        en_m = en_m | d[3:0];
      end else begin
        wr(`OFS_EN_CLR, d, r);
        en_m = en_m & ~d[3:0];
      end
      rd(`OFS_EN_SET, v, r);
      chk(v, low4(en_m));
      rd(`OFS_EN_CLR, v, r);
      chk(v, low4(en_m));
      p = 4'($urandom());
      pulse(p);
      chk({31'h0, tx_completion_irq}, irq_exp(raw_m, en_m));
      rd(`OFS_MASKED, v, r);
      chk(v, low4(raw_m & en_m));
      if ($urandom_range(1) == 1) begin
        rd(`OFS_RAW, v, r);
        chk(v, low4(raw_m));
        raw_m = '0;
        repeat (3) @(posedge aclk);
        chk({31'h0, tx_completion_irq}, 32'h0);
      end
    end
    // flags held under a closed mask raise the line once enabled
    wr(`OFS_EN_CLR, 32'h0000_000f, r);
    en_m = '0;
    // a write without the low byte lane must leave the mask alone
    strb_use = 4'he;
    wr(`OFS_EN_SET, 32'h0000_000f, r);
    strb_use = 4'hf;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(`OFS_EN_SET, v, r);
    chk(v, low4(en_m));
    pulse(4'h9);
    chk({31'h0, tx_completion_irq}, 32'h0);
    wr(`OFS_EN_SET, 32'h0000_0008, r);
    en_m = 4'h8;
    repeat (3) @(posedge aclk);
    chk({31'h0, tx_completion_irq}, irq_exp(raw_m, en_m));
    rd(`OFS_MASKED, v, r);
    chk(v, low4(raw_m & en_m));
    rd(`OFS_RAW, v, r);
    chk(v, low4(raw_m));
    repeat (3) @(posedge aclk);
    chk({31'h0, tx_completion_irq}, 32'h0);
    rd(`OFS_RAW, v, r);
    chk(v, 32'h0);
    // a completion in the clearing cycle of a raw read survives it
    pulse(4'h2);
    fork
      rd(`OFS_RAW, v, r);
      begin
        repeat (2) @(posedge aclk);
        tx_done_pulse <= 4'h4;
        @(posedge aclk);
        tx_done_pulse <= '0;
      end
    join
    chk(v, low4(4'h2));
    rd(`OFS_RAW, v, r);
    chk(v, low4(4'h4));
    report_and_stop();
  end

endmodule // dma_completion_irq_regs_test
